/* rtl/ext_dma_channel.sv */
// external-bus dma channel: mode control bits, request sensing, pins
// Summary of operation
// [RULE1] nmi during a block transfer sets the block error flag
// [RULE2] nmi during a block transfer stops the channel at once
// [RULE3] after an abort, addresses point at the next transfer
// [RULE4] partly moved block is lost; queued commands are flushed
// [RULE5] error flag clears only by writing 0 after reading it as 1
// [RULE6] request-acknowledge pin driven only when its enable is 1
// [RULE7] transfer-end pin driven only when its enable is 1
// [RULE8] external request: low level when sense is 0, falling edge when 1
// [RULE9] first transfer after enable always uses low-level sensing
// [RULE10] address mode 0 gives dual, 1 gives single address transfers
// [RULE11] single-address acknowledge pin used only in single mode
// [RULE12] block transfer mode only with mode field 11
// [RULE13] channel active clears on reset, nmi or hardware standby
// [RULE14] writing 1 to the block error flag has no effect
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module ext_dma_channel #(
    parameter int CMD_DEPTH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register port
    input wire ext_dma_pkg::reg_bus_t reg_bus_i,
    output logic [31:0] rdata_o,
    // system events
    input wire logic nmi_i,
    input wire logic standby_i,
    // external request pin
    input wire logic external_request_pin_n_i,
    // output pins
    output logic req_ack_start_pin_n_o,
    output logic req_ack_start_pin_oe_n_o,
    output logic xfer_end_pin_n_o,
    output logic xfer_end_pin_oe_n_o,
    output logic single_addr_ack_pin_n_o,
    output logic single_addr_ack_pin_oe_n_o,
    // transfer commands to the bus-cycle logic
    output logic cmd_valid_o,
    output ext_dma_pkg::xfer_cmd_t cmd_o,
    input wire logic cmd_ready_i
);
    import ext_dma_pkg::*;

    mode_ctrl_t mode_ff, wr_fields;
    chan_state_t state_ff;
    logic [31:0] src_ff, dst_ff, rdata_ff;
    logic [15:0] count_ff;
    logic [7:0] block_size_ff, blk_left_ff, cur_left;
    logic bef_read_ff, stop_pend_ff, first_xfer_ff, req_prev_ff;
    logic edge_pend_ff, ack_pulse_ff, end_pulse_ff, single_ack_ff;
    logic wr_mode, rd_mode, block_mode, abort, fall_now, req_ok;
    logic buf_in_ready, start, push, last_of_block, end_of_run;
    logic bef_clear, flush;
    xfer_cmd_t nxt_cmd;

    function automatic logic reg_hit(input reg_bus_t b, input logic [7:0] o);
        reg_hit = (b.addr == o);
    endfunction
    // ==========================================================
    // decode and request sensing
    assign wr_fields = mode_ctrl_t'(reg_bus_i.wdata[MODE_FIELD_LSB +: MODE_FIELD_W]);
    assign wr_mode = reg_bus_i.wr && reg_hit(reg_bus_i, MODE_CTRL_OFS);
    assign rd_mode = reg_bus_i.rd && reg_hit(reg_bus_i, MODE_CTRL_OFS);
    assign block_mode = (mode_ff.mode == MODE_BLOCK); // [RULE12]
    assign abort = nmi_i || standby_i;
    assign fall_now = req_prev_ff && !external_request_pin_n_i;
    assign req_ok = !mode_ff.mode[1] ? 1'b1
        : (first_xfer_ff || !mode_ff.sense)
        ? !external_request_pin_n_i // [RULE8] [RULE9]
        : (edge_pend_ff || fall_now); // [RULE8]
    assign start = (state_ff == ST_ARMED) && mode_ff.active && req_ok
        && buf_in_ready && !abort;
    assign push = start || ((state_ff == ST_MOVE) && buf_in_ready && !abort);
    assign cur_left = (state_ff == ST_ARMED)
        ? (block_mode ? block_size_ff - 8'h01 : 8'h00) : blk_left_ff;
    assign last_of_block = (cur_left == 8'h00);
    assign end_of_run = push && last_of_block && (count_ff == 16'h0001);
    assign bef_clear = wr_mode && !wr_fields.bef && bef_read_ff; // [RULE5]
    assign flush = nmi_i && (state_ff == ST_MOVE); // [RULE4]
    assign nxt_cmd = '{src: src_ff, dst: dst_ff, single: mode_ff.address_mode_select}; // [RULE10]

    // ==========================================================
    // mode control register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_ff <= mode_ctrl_t'(MODE_CTRL_RST); // [RULE13]
        end else begin
            if (wr_mode) begin
                mode_ff.ack_oe <= wr_fields.ack_oe;
                mode_ff.end_oe <= wr_fields.end_oe;
                mode_ff.sense <= wr_fields.sense;
                mode_ff.address_mode_select <= wr_fields.address_mode_select;
                mode_ff.mode <= wr_fields.mode;
            end
            if (abort) begin
                mode_ff.active <= 1'b0; // [RULE13]
            end else if (end_of_run) begin
                mode_ff.active <= 1'b0;
            end else if (push && last_of_block && stop_pend_ff) begin
                mode_ff.active <= 1'b0;
            end else if (wr_mode && wr_fields.active) begin
                mode_ff.active <= 1'b1;
            end else if (wr_mode && state_ff != ST_MOVE) begin
                mode_ff.active <= 1'b0;
            end
            // set wins over clear; a written 1 is ignored
            if (nmi_i && block_mode && state_ff == ST_MOVE) begin
                mode_ff.bef <= 1'b1; // [RULE1]
            end else if (bef_clear) begin
                mode_ff.bef <= 1'b0; // [RULE5] [RULE14]
            end
        end
    end

    // ==========================================================
    // read-then-write-zero tracking and deferred stop
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bef_read_ff <= 1'b0;
            stop_pend_ff <= 1'b0;
        end else begin
            if (rd_mode && mode_ff.bef) begin
                bef_read_ff <= 1'b1; // [RULE5]
            end else if (wr_mode) begin
                bef_read_ff <= 1'b0;
            end
            if (abort || !mode_ff.active || (push && last_of_block)) begin
                stop_pend_ff <= 1'b0;
            end else if (wr_mode && !wr_fields.active
                && state_ff == ST_MOVE) begin
                stop_pend_ff <= 1'b1;
            end
        end
    end

    // ==========================================================
    // other registers and address update
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            src_ff <= ADDR_RST;
            dst_ff <= ADDR_RST;
            count_ff <= XFER_COUNT_RST;
            block_size_ff <= BLOCK_SIZE_RST;
        end else if (push) begin
            src_ff <= src_ff + ADDR_STEP; // [RULE3]
            dst_ff <= dst_ff + ADDR_STEP; // [RULE3]
            if (last_of_block) begin
                count_ff <= count_ff - 16'h0001;
            end
        end else if (reg_bus_i.wr && !mode_ff.active) begin
            unique case (reg_bus_i.addr)
                SRC_ADDR_OFS: src_ff <= reg_bus_i.wdata;
                DST_ADDR_OFS: dst_ff <= reg_bus_i.wdata;
                XFER_COUNT_OFS: count_ff <= reg_bus_i.wdata[15:0];
                BLOCK_SIZE_OFS: block_size_ff <= reg_bus_i.wdata[7:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // read data
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (reg_bus_i.rd) begin
            unique case (reg_bus_i.addr)
                MODE_CTRL_OFS: rdata_ff <= {16'h0000, mode_ff, 8'h00};
                SRC_ADDR_OFS: rdata_ff <= src_ff;
                DST_ADDR_OFS: rdata_ff <= dst_ff;
                XFER_COUNT_OFS: rdata_ff <= {16'h0000, count_ff};
                BLOCK_SIZE_OFS: rdata_ff <= {24'h000000, block_size_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end
    assign rdata_o = rdata_ff;

    // ==========================================================
    // channel sequencing
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_IDLE;
            blk_left_ff <= 8'h00;
        end else if (abort) begin
            state_ff <= ST_IDLE; // [RULE2]
        end else begin
            unique case (state_ff)
                ST_IDLE: state_ff <= mode_ff.active ? ST_ARMED : ST_IDLE;
                ST_ARMED: begin
                    if (!mode_ff.active) begin
                        state_ff <= ST_IDLE;
                    end else if (start) begin
                        blk_left_ff <= cur_left - 8'h01;
                        if (!last_of_block) begin
                            state_ff <= ST_MOVE;
                        end else if (end_of_run) begin
                            state_ff <= ST_IDLE;
                        end else if (mode_ff.mode != MODE_BURST) begin
                            state_ff <= ST_GAP;
                        end
                    end
                end
                ST_MOVE: begin
                    if (push) begin
                        blk_left_ff <= blk_left_ff - 8'h01;
                        if (last_of_block) begin
                            state_ff <= end_of_run ? ST_IDLE : ST_GAP;
                        end
                    end
                end
                ST_GAP: state_ff <= mode_ff.active ? ST_ARMED : ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // request pin history
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            req_prev_ff <= 1'b1;
            edge_pend_ff <= 1'b0;
            first_xfer_ff <= 1'b0;
        end else begin
            req_prev_ff <= external_request_pin_n_i;
            if (start || !mode_ff.active) begin
                edge_pend_ff <= 1'b0;
            end else if (fall_now) begin
                edge_pend_ff <= 1'b1; // [RULE8]
            end
            if (wr_mode && wr_fields.active && !mode_ff.active) begin
                first_xfer_ff <= 1'b1; // [RULE9]
            end else if (start) begin
                first_xfer_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // output pins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_pulse_ff <= 1'b0;
            end_pulse_ff <= 1'b0;
            single_ack_ff <= 1'b0;
        end else begin
            ack_pulse_ff <= start && mode_ff.ack_oe; // [RULE6]
            end_pulse_ff <= end_of_run && mode_ff.end_oe; // [RULE7]
            single_ack_ff <= push && mode_ff.address_mode_select; // [RULE11]
        end
    end
    assign req_ack_start_pin_n_o = !ack_pulse_ff;
    assign req_ack_start_pin_oe_n_o = !mode_ff.ack_oe; // [RULE6]
    assign xfer_end_pin_n_o = !end_pulse_ff;
    assign xfer_end_pin_oe_n_o = !mode_ff.end_oe; // [RULE7]
    assign single_addr_ack_pin_n_o = !single_ack_ff;
    assign single_addr_ack_pin_oe_n_o = !mode_ff.address_mode_select; // [RULE11]

    // ==========================================================
    // command buffer
    ext_dma_cmd_fifo #(
        .WIDTH($bits(xfer_cmd_t)),
        .DEPTH(CMD_DEPTH)
    ) u_cmd_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .flush_i(flush),
        .in_valid_i(push),
        .in_data_i(nxt_cmd),
        .in_ready_o(buf_in_ready),
        .out_valid_o(cmd_valid_o),
        .out_data_o(cmd_o),
        .out_ready_i(cmd_ready_i)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_bef_on_nmi: assert property ( // [RULE1]
        nmi_i && block_mode && state_ff == ST_MOVE |=> mode_ff.bef)
        else $error("block error flag not set by nmi");
    chk_stop_on_abort: assert property ( // [RULE2]
        abort |=> state_ff == ST_IDLE && !mode_ff.active && !push)
        else $error("channel still running after abort");
    chk_addr_next: assert property ( // [RULE3]
        push |=> src_ff == $past(src_ff) + ADDR_STEP
            && dst_ff == $past(dst_ff) + ADDR_STEP)
        else $error("addresses not advanced past transfer");
    chk_block_lost: assert property ( // [RULE4]
        flush |=> !cmd_valid_o)
        else $error("commands of aborted block survive");
    chk_bef_clear: assert property ( // [RULE5]
        mode_ff.bef && !bef_read_ff && !(rd_mode) |=> mode_ff.bef)
        else $error("error flag cleared without prior read");
    chk_bef_no_set: assert property ( // [RULE14]
        !mode_ff.bef && !nmi_i |=> !mode_ff.bef)
        else $error("error flag set by software");
    chk_ack_pin: assert property ( // [RULE6]
        start && mode_ff.ack_oe |=> !req_ack_start_pin_n_o
            && !req_ack_start_pin_oe_n_o ##1 req_ack_start_pin_n_o
            == !$past(start && mode_ff.ack_oe))
        else $error("acknowledge pulse wrong");
    chk_end_pin: assert property ( // [RULE7]
        !mode_ff.end_oe |=> xfer_end_pin_n_o)
        else $error("end pin pulsed while disabled");
    chk_edge_sense: assert property ( // [RULE8]
        mode_ff.mode[1] && mode_ff.sense && !first_xfer_ff
            && !edge_pend_ff && !req_prev_ff |-> !start)
        else $error("held low level started edge-sensed transfer");
    chk_first_level: assert property ( // [RULE9]
        state_ff == ST_ARMED && mode_ff.active && first_xfer_ff
            && !external_request_pin_n_i && buf_in_ready && !abort
            |-> start)
        else $error("first request level not honoured");
    chk_addr_mode: assert property ( // [RULE10]
        cmd_valid_o && !$past(cmd_valid_o)
            |-> cmd_o.single == $past(mode_ff.address_mode_select))
        else $error("command address mode wrong");
    chk_dual_no_ack: assert property ( // [RULE11]
        !mode_ff.address_mode_select |=> single_addr_ack_pin_n_o)
        else $error("single acknowledge in dual mode");
    chk_block_mode: assert property ( // [RULE12]
        state_ff == ST_MOVE |-> block_mode)
        else $error("block move outside mode 11");

    cov_block_done: cover property (
        state_ff == ST_MOVE ##1 state_ff == ST_GAP);
    cov_nmi_abort: cover property (flush ##1 mode_ff.bef);
    cov_edge_start: cover property (edge_pend_ff && start);
    cov_stall: cover property (cmd_valid_o && !cmd_ready_i && !buf_in_ready);
endmodule // ext_dma_channel
`default_nettype wire

/* rtl/ext_dma_cmd_fifo.sv */
// small command buffer with valid/ready on both sides and flush
`timescale 1ns/1ns
`default_nettype none
module ext_dma_cmd_fifo #(
    parameter int WIDTH = 65,
    parameter int DEPTH = 2
) (
    // clock, reset and flush
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic flush_i,
    // fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] DEPTH_CNT = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wptr_ff;
    logic [PW-1:0] rptr_ff;
    logic [PW:0] fill_ff;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign in_ready_o = (fill_ff != DEPTH_CNT);
    assign out_valid_o = (fill_ff != '0);
    assign out_data_o = mem_ff[rptr_ff];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // ==========================================================
    // storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wptr_ff] <= in_data_i;
        end
    end

    // ==========================================================
    // pointers and fill level
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || flush_i) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            fill_ff <= '0;
        end else begin
            if (push) begin
                wptr_ff <= ptr_inc(wptr_ff);
            end
            if (pop) begin
                rptr_ff <= ptr_inc(rptr_ff);
            end
            fill_ff <= fill_ff + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // ext_dma_cmd_fifo
`default_nettype wire

/* rtl/ext_dma_pkg.sv */
// shared constants and types for the external-bus dma channel
package ext_dma_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] MODE_CTRL_OFS = 8'h00;
    localparam logic [7:0] SRC_ADDR_OFS = 8'h04;
    localparam logic [7:0] DST_ADDR_OFS = 8'h08;
    localparam logic [7:0] XFER_COUNT_OFS = 8'h0C;
    localparam logic [7:0] BLOCK_SIZE_OFS = 8'h10;

    // ==========================================================
    // mode control field positions (bits 15..8 held)
    localparam int ACTIVE_BIT = 15;
    localparam int BEF_BIT = 14;
    localparam int MODE_FIELD_LSB = 8;
    localparam int MODE_FIELD_W = 8;

    // ==========================================================
    // reset values and encodings
    localparam logic [7:0] MODE_CTRL_RST = 8'h00;
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam logic [15:0] XFER_COUNT_RST = 16'h0000;
    localparam logic [7:0] BLOCK_SIZE_RST = 8'h01;
    localparam logic [1:0] MODE_BURST = 2'b01;
    localparam logic [1:0] MODE_BLOCK = 2'b11;
    localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
    localparam int CMD_DEPTH = 2;

    // ==========================================================
    // types
    typedef struct packed {
        logic active;
        logic bef;
        logic ack_oe;
        logic end_oe;
        logic sense;
        logic address_mode_select;
        logic [1:0] mode;
    } mode_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_bus_t;

    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
        logic single;
    } xfer_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_MOVE,
        ST_GAP
    } chan_state_t;

endpackage

/* verification/ext_req_partner.sv */
// far-side model: external requester and command sink
`timescale 1ns/1ns
`default_nettype none
module ext_req_partner (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // bench commands
    input wire logic req_i,
    input wire logic stall_i,
    // device side
    output logic external_request_pin_n_o,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    // accepted command count
    output logic [7:0] taken_o
);
    // ==========================================================
    // request pin, idle high as with a pull-up
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            external_request_pin_n_o <= 1'b1;
        end else begin
            external_request_pin_n_o <= !req_i;
        end
    end
    // ==========================================================
    // command sink, stalls on request
    assign cmd_ready_o = !stall_i;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            taken_o <= 8'h00;
        end else if (cmd_valid_i && cmd_ready_o) begin
            taken_o <= taken_o + 8'h01;
        end
    end
endmodule // ext_req_partner
`default_nettype wire

/* verification/tb.sv */
// testbench for the external-bus dma channel
`timescale 1ns/1ns
`default_nettype none
module tb;
    import ext_dma_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    reg_bus_t bus = '0;
    logic [31:0] rdata;
    logic nmi = 1'b0;
    logic standby = 1'b0;
    logic req = 1'b0;
    logic stall = 1'b0;
    logic pin_n;
    logic ack_n, ack_oe_n, end_n, end_oe_n, sgl_n, sgl_oe_n;
    logic cmd_valid, cmd_ready;
    xfer_cmd_t cmd;
    logic [7:0] taken;
    int num_errors = 0;
    int n_tests = 0;
    always #10 clk_i = ~clk_i;
    ext_dma_channel ext_dma_channel_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .reg_bus_i(bus), .rdata_o(rdata), .nmi_i(nmi), .standby_i(standby),
        .external_request_pin_n_i(pin_n), .req_ack_start_pin_n_o(ack_n),
        .req_ack_start_pin_oe_n_o(ack_oe_n), .xfer_end_pin_n_o(end_n),
        .xfer_end_pin_oe_n_o(end_oe_n), .single_addr_ack_pin_n_o(sgl_n),
        .single_addr_ack_pin_oe_n_o(sgl_oe_n), .cmd_valid_o(cmd_valid),
        .cmd_o(cmd), .cmd_ready_i(cmd_ready));
    ext_req_partner ext_req_partner_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .req_i(req), .stall_i(stall), .external_request_pin_n_o(pin_n),
        .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .taken_o(taken));
    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_valid();
        for (int i = 0; i < 30 && cmd_valid !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        logic [31:0] v;
        check(ack_oe_n, 1'b1);
        check(end_oe_n, 1'b1);
        check(sgl_oe_n, 1'b1);
        check(cmd_valid, 1'b0);
        check({ack_n, end_n, sgl_n}, 3'b111);
        rd(MODE_CTRL_OFS, v);
        check(v, 32'h0);
        rd(8'h20, v);
        check(v, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_auto();
        logic [31:0] v;
        wr(SRC_ADDR_OFS, 32'h100);
        wr(DST_ADDR_OFS, 32'h200);
        wr(XFER_COUNT_OFS, 32'h1);
        wr(MODE_CTRL_OFS, 32'hB000);
        wait_valid();
        check({cmd.src, cmd.dst}, {32'h100, 32'h200});
        check(cmd.single, 1'b0);
        check({ack_oe_n, end_oe_n, sgl_oe_n}, 3'b001);
        check({ack_n, end_n, sgl_n}, 3'b001);
        rd(SRC_ADDR_OFS, v);
        check(v, 32'h104);
        wr(MODE_CTRL_OFS, 32'h0);
        #1 check({ack_oe_n, end_oe_n}, 2'b11);
        $display("auto test done");
    endtask
    task automatic t_single();
        logic [31:0] v;
        wr(SRC_ADDR_OFS, 32'h300);
        wr(XFER_COUNT_OFS, 32'h1);
        wr(MODE_CTRL_OFS, 32'h8400);
        wait_valid();
        check({cmd.single, sgl_oe_n}, 2'b10);
        check({ack_n, end_n, sgl_n}, 3'b110);
        wr(MODE_CTRL_OFS, 32'h4000);
        rd(MODE_CTRL_OFS, v);
        check(v, 32'h0);
        $display("single test done");
    endtask
    task automatic t_block_nmi();
        logic [31:0] v;
        stall <= 1'b1;
        wr(SRC_ADDR_OFS, 32'h1000);
        wr(XFER_COUNT_OFS, 32'h1);
        wr(BLOCK_SIZE_OFS, 32'h4);
        wr(MODE_CTRL_OFS, 32'h8300);
        req <= 1'b1;
        cycles(8);
        #1 check(cmd_valid, 1'b1);
        @(posedge clk_i);
        nmi <= 1'b1;
        @(posedge clk_i);
        nmi <= 1'b0;
        req <= 1'b0;
        @(posedge clk_i);
        #1 check(cmd_valid, 1'b0);
        rd(SRC_ADDR_OFS, v);
        check(v, 32'h1008);
        wr(MODE_CTRL_OFS, 32'h0);
        rd(MODE_CTRL_OFS, v);
        check(v, 32'h4000);
        wr(MODE_CTRL_OFS, 32'h0);
        rd(MODE_CTRL_OFS, v);
        check(v, 32'h0);
        stall <= 1'b0;
        $display("block abort test done");
    endtask
    task automatic t_sense();
        logic [7:0] base;
        logic [7:0] d1;
        logic [31:0] v;
        base = taken;
        wr(XFER_COUNT_OFS, 32'h5);
        req <= 1'b1;
        wr(MODE_CTRL_OFS, 32'h8A00);
        cycles(12);
        d1 = taken - base;
        check(d1, 8'h1);
        req <= 1'b0;
        cycles(3);
        req <= 1'b1;
        cycles(12);
        check(taken - base - d1, 8'h1);
        req <= 1'b0;
        wr(MODE_CTRL_OFS, 32'h0);
        cycles(4);
        base = taken;
        wr(XFER_COUNT_OFS, 32'h3);
        wr(MODE_CTRL_OFS, 32'h8200);
        req <= 1'b1;
        cycles(20);
        check(taken - base, 8'h3);
        req <= 1'b0;
        rd(MODE_CTRL_OFS, v);
        check(v[15], 1'b0);
        $display("sense test done");
    endtask
    task automatic t_standby();
        logic [31:0] v;
        wr(MODE_CTRL_OFS, 32'h8200);
        @(posedge clk_i);
        standby <= 1'b1;
        @(posedge clk_i);
        standby <= 1'b0;
        rd(MODE_CTRL_OFS, v);
        check(v, 32'h0200);
        $display("standby test done");
    endtask
    // ==========================================================
    // verdict
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        cycles(6);
        rst_n_i <= 1'b1;
        #1;
        t_reset();
        t_auto();
        t_single();
        t_block_nmi();
        t_sense();
        t_standby();
        end_of_test();
    end
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
endmodule // tb
`default_nettype wire
